//--- rtl/crs_card_reset.sv
// Card reset release sequencer and digital supply fault control.
// Assumes etu_tick_i is a one-cycle pulse on ref_clk_i, and that the
// supply comparator and card supply monitor drive asynchronous levels.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Eight-bit release delay register, reset 0x70, counts elementary time units.
// - Zero delay and hold clear: release as soon as card supply is good.
// - Nonzero delay postpones the release by that many time units.
// - Setting hold bit drives the card reset pin low.
// - Clearing hold bit releases reset only after the programmed delay.
// - Hold set before power-up keeps reset until delay after clearing.
// - Release logic acts on the currently selected card interface only.
// - Enabled fault and supply below threshold deactivates the active card.
// - Override high uses threshold field; low uses factory default threshold.
// - Writing one to the disable bit turns supply fault operation off.
// - Threshold codes 000 to 111 span 2.3 V to 3.0 V in 0.1 V.
// - Fault control register at 0xFFD4, reset 0x00, bits 6, 5, 2:0.
module crs_card_reset #(
  parameter int unsigned NUM_CARDS         = 2,
  parameter logic [2:0]  FACTORY_THRESHOLD = 3'h0
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     nrst_i,
  input  wire crs_pkg::crs_bus_req_type bus_i,
  output logic                    [7:0] rdata_o,
  input  wire logic                     etu_tick_i,
  input  wire logic               [1:0] card_select_i,
  input  wire logic                     card_supply_good_i,
  input  wire logic                     vdd_below_i,
  output logic          [NUM_CARDS-1:0] card_rst_n_o,
  output logic          [NUM_CARDS-1:0] card_deactivate_o,
  output logic                    [2:0] supply_fault_threshold_o,
  output logic                          supply_fault_flag_o
);

  generate
    if (NUM_CARDS < 1 || NUM_CARDS > 4) begin : g_bad_cards
      $error("crs_card_reset: NUM_CARDS must be 1 to 4");
    end
  endgenerate

  typedef struct packed {
    crs_pkg::crs_seq_state_type st;
    logic [7:0]                 count;
    logic [7:0]                 rel_delay;
    logic [7:0]                 sig_ctl;
    logic [7:0]                 fault_ctl;
    logic                       fault_flag;
    logic [7:0]                 rdata;
    logic [2:0]                 threshold;
    logic [1:0]                 sel;
    logic [NUM_CARDS-1:0]       rst_n;
    logic [NUM_CARDS-1:0]       deact;
  } crs_main_state_type;

  crs_main_state_type s_q;
  crs_main_state_type s_d;

  logic [1:0] pins_s;
  logic       supply_good_s;
  logic       vdd_below_s;
  logic       hold_reset;
  logic       fault_disable;
  logic       threshold_override;
  logic       fault_active;
  logic       sel_changed;
  logic       flag_clear;
  logic [7:0] supply_ctl_rd;
  logic [NUM_CARDS-1:0] sel_onehot;

  crs_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .async_i   ({card_supply_good_i, vdd_below_i}),
    .sync_o    (pins_s)
  );

  assign supply_good_s      = pins_s[1];
  assign vdd_below_s        = pins_s[0];
  assign hold_reset         = s_q.sig_ctl[crs_pkg::CRS_HOLD_RESET_BIT];
  assign fault_disable      = s_q.fault_ctl[crs_pkg::CRS_FAULT_DIS_BIT];
  assign threshold_override = s_q.fault_ctl[crs_pkg::CRS_OVERRIDE_BIT];
  // Disable bit is active high despite its name
  assign fault_active       = !fault_disable && vdd_below_s;
  assign sel_changed        = (card_select_i != s_q.sel);
  assign flag_clear         = bus_i.wr && (bus_i.addr == crs_pkg::CRS_ADDR_SUPPLY_CTL)
                              && bus_i.wdata[crs_pkg::CRS_FAULT_FLAG_BIT];

  always_comb begin
    supply_ctl_rd = 8'h00;
    supply_ctl_rd[crs_pkg::CRS_FAULT_FLAG_BIT]  = s_q.fault_flag;
    supply_ctl_rd[crs_pkg::CRS_SUPPLY_GOOD_BIT] = supply_good_s;
  end

  always_comb begin
    s_d       = s_q;
    s_d.sel   = card_select_i;
    s_d.rdata = 8'h00;

    // Register writes
    if (bus_i.wr) begin
      case (bus_i.addr)
        crs_pkg::CRS_ADDR_SIGNAL_CTL: begin
          s_d.sig_ctl = bus_i.wdata & crs_pkg::CRS_SIGNAL_CTL_MASK;
        end
        crs_pkg::CRS_ADDR_REL_DELAY: begin
          s_d.rel_delay = bus_i.wdata;
        end
        crs_pkg::CRS_ADDR_FAULT_CTL: begin
          s_d.fault_ctl = bus_i.wdata & crs_pkg::CRS_FAULT_CTL_MASK;
        end
        default: begin
        end
      endcase
    end

    // Register reads, data in the following cycle only
    if (bus_i.rd) begin
      case (bus_i.addr)
        crs_pkg::CRS_ADDR_SUPPLY_CTL: s_d.rdata = supply_ctl_rd;
        crs_pkg::CRS_ADDR_SIGNAL_CTL: s_d.rdata = s_q.sig_ctl;
        crs_pkg::CRS_ADDR_REL_DELAY:  s_d.rdata = s_q.rel_delay;
        crs_pkg::CRS_ADDR_FAULT_CTL:  s_d.rdata = s_q.fault_ctl;
        default:                      s_d.rdata = 8'h00;
      endcase
    end

    // Sticky fault flag; a new fault beats a clear in the same cycle
    s_d.fault_flag = fault_active || (s_q.fault_flag && !flag_clear);

    // Factory default applies until firmware overrides after power-up
    if (threshold_override) begin
      s_d.threshold = s_q.fault_ctl[crs_pkg::CRS_THRESH_LSB +: crs_pkg::CRS_THRESH_W];
    end else begin
      s_d.threshold = FACTORY_THRESHOLD;
    end

    // Release sequencer
    case (s_q.st)
      crs_pkg::CRS_ST_HOLD: begin
        if (!hold_reset && supply_good_s) begin
          s_d.count = s_q.rel_delay;
          if (s_q.rel_delay == 8'h00) begin
            s_d.st = crs_pkg::CRS_ST_RELEASED;
          end else begin
            s_d.st = crs_pkg::CRS_ST_DELAY;
          end
        end
      end
      crs_pkg::CRS_ST_DELAY: begin
        if (etu_tick_i) begin
          if (s_q.count <= 8'h01) begin
            s_d.count = 8'h00;
            s_d.st    = crs_pkg::CRS_ST_RELEASED;
          end else begin
            s_d.count = s_q.count - 8'h01;
          end
        end
      end
      crs_pkg::CRS_ST_RELEASED: begin
      end
      default: begin
        s_d.st = crs_pkg::CRS_ST_HOLD;
      end
    endcase

    // Any of these forces reset back on; a fresh release restarts the count
    if (hold_reset || !supply_good_s || fault_active || sel_changed) begin
      s_d.st = crs_pkg::CRS_ST_HOLD;
    end

    // Pins follow the state just decided, so they move with it
    s_d.rst_n = (s_d.st == crs_pkg::CRS_ST_RELEASED) ? sel_onehot : '0;
    s_d.deact = fault_active ? sel_onehot : '0;
  end

  // Only the selected interface is released or deactivated
  for (genvar i = 0; i < NUM_CARDS; i++) begin : g_card
    assign sel_onehot[i] = (card_select_i == 2'(i));
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_q.st         <= crs_pkg::CRS_ST_HOLD;
      s_q.count      <= 8'h00;
      s_q.rel_delay  <= crs_pkg::CRS_REL_DELAY_RST;
      s_q.sig_ctl    <= crs_pkg::CRS_SIGNAL_CTL_RST;
      s_q.fault_ctl  <= crs_pkg::CRS_FAULT_CTL_RST;
      s_q.fault_flag <= 1'b0;
      s_q.rdata      <= 8'h00;
      s_q.threshold  <= FACTORY_THRESHOLD;
      s_q.sel        <= 2'h0;
      s_q.rst_n      <= '0;
      s_q.deact      <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o                  = s_q.rdata;
  assign card_rst_n_o             = s_q.rst_n;
  assign card_deactivate_o        = s_q.deact;
  assign supply_fault_threshold_o = s_q.threshold;
  assign supply_fault_flag_o      = s_q.fault_flag;

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic [NUM_CARDS-1:0] sel_mask;
  always_comb begin
    sel_mask = '0;
    for (int j = 0; j < NUM_CARDS; j++) begin
      sel_mask[j] = (s_q.sel == j[1:0]);
    end
  end

  AST_DELAY_RESET_VALUE: assert property (
    $rose(nrst_i) |-> (s_q.rel_delay == crs_pkg::CRS_REL_DELAY_RST))
    else $error("release delay not 0x70 after reset");

  AST_ZERO_DELAY_RELEASE: assert property (
    (s_q.st == crs_pkg::CRS_ST_HOLD) && (s_q.rel_delay == 8'h00) && !hold_reset
    && supply_good_s && !fault_active && !sel_changed
    |=> (s_q.st == crs_pkg::CRS_ST_RELEASED) && (card_rst_n_o != '0))
    else $error("zero delay did not release at once");

  AST_DELAY_COUNTS_DOWN: assert property (
    (s_q.st == crs_pkg::CRS_ST_DELAY) && etu_tick_i && (s_q.count > 8'h01)
    && !hold_reset && supply_good_s && !fault_active && !sel_changed
    |=> (s_q.count == $past(s_q.count) - 8'h01) && (s_q.st == crs_pkg::CRS_ST_DELAY))
    else $error("delay counter did not step by one");

  AST_NO_RELEASE_WITHOUT_TICKS: assert property (
    (s_q.st == crs_pkg::CRS_ST_DELAY) && !etu_tick_i |=> (card_rst_n_o == '0))
    else $error("reset released before delay elapsed");

  AST_HOLD_ASSERTS_RESET: assert property (
    hold_reset |=> (card_rst_n_o == '0))
    else $error("card reset not low while hold bit set");

  AST_CLEAR_STARTS_DELAY: assert property (
    $fell(hold_reset) && (s_q.st == crs_pkg::CRS_ST_HOLD) && (s_q.rel_delay != 8'h00)
    && supply_good_s && !fault_active && !sel_changed
    |=> (s_q.st == crs_pkg::CRS_ST_DELAY) && (s_q.count == $past(s_q.rel_delay))
    ##0 (card_rst_n_o == '0))
    else $error("hold clear did not start delay");

  AST_NO_SUPPLY_NO_RELEASE: assert property (
    !supply_good_s |=> (card_rst_n_o == '0))
    else $error("reset released without card supply");

  AST_ONLY_SELECTED_CARD: assert property (
    ((card_rst_n_o | card_deactivate_o) & ~sel_mask) == '0)
    else $error("unselected card driven");

  AST_FAULT_DEACTIVATES: assert property (
    fault_active |=> ((card_deactivate_o & sel_mask) == sel_mask) && (card_rst_n_o == '0)
    && supply_fault_flag_o)
    else $error("supply fault did not deactivate card");

  AST_DISABLE_BLOCKS_FAULT: assert property (
    fault_disable && $past(fault_disable) |-> (card_deactivate_o == '0))
    else $error("fault acted while disabled");

  AST_THRESHOLD_SOURCE: assert property (
    ##1 (supply_fault_threshold_o == ($past(threshold_override)
      ? $past(s_q.fault_ctl[2:0]) : FACTORY_THRESHOLD)))
    else $error("wrong threshold source");

  AST_FAULT_CTL_WRITE: assert property (
    bus_i.wr && (bus_i.addr == crs_pkg::CRS_ADDR_FAULT_CTL)
    |=> s_q.fault_ctl == ($past(bus_i.wdata) & crs_pkg::CRS_FAULT_CTL_MASK))
    else $error("fault control write not stored");

  CVR_DELAYED_RELEASE: cover property (
    (s_q.st == crs_pkg::CRS_ST_DELAY) ##1 (s_q.st == crs_pkg::CRS_ST_RELEASED));

  CVR_FAULT_WHILE_RELEASED: cover property (
    (s_q.st == crs_pkg::CRS_ST_RELEASED) && fault_active);

  CVR_HOLD_THEN_RELEASE: cover property (
    $fell(hold_reset) ##[1:300] (card_rst_n_o != '0));

  CVR_FLAG_CLEAR: cover property (
    s_q.fault_flag && flag_clear && !fault_active ##1 !s_q.fault_flag);

endmodule : crs_card_reset

`default_nettype wire

//--- shared/crs_pkg.sv
// Constants, register map and carrier types of the card reset sequencer
// and supply fault block.
// Assumes an 8-bit register port with 16-bit addresses.
package crs_pkg;

  // Register addresses
  localparam logic [15:0] CRS_ADDR_SUPPLY_CTL = 16'hFE03;
  localparam logic [15:0] CRS_ADDR_SIGNAL_CTL = 16'hFE0A;
  localparam logic [15:0] CRS_ADDR_REL_DELAY  = 16'hFE22;
  localparam logic [15:0] CRS_ADDR_FAULT_CTL  = 16'hFFD4;

  // Field positions
  localparam int unsigned CRS_FAULT_FLAG_BIT   = 5;
  localparam int unsigned CRS_SUPPLY_GOOD_BIT  = 3;
  localparam int unsigned CRS_HOLD_RESET_BIT   = 7;
  localparam int unsigned CRS_OVERRIDE_BIT     = 6;
  localparam int unsigned CRS_FAULT_DIS_BIT    = 5;
  localparam int unsigned CRS_THRESH_LSB       = 0;
  localparam int unsigned CRS_THRESH_W         = 3;

  // Reset values and write masks
  localparam logic [7:0] CRS_REL_DELAY_RST  = 8'h70;
  localparam logic [7:0] CRS_FAULT_CTL_RST  = 8'h00;
  localparam logic [7:0] CRS_SIGNAL_CTL_RST = 8'h00;
  localparam logic [7:0] CRS_FAULT_CTL_MASK = 8'h67;
  localparam logic [7:0] CRS_SIGNAL_CTL_MASK = 8'hBF;

  // Threshold codes: 2.3 V at the lowest, 0.1 V per step, 3.0 V at the top
  localparam logic [2:0] CRS_THRESH_MIN = 3'h0;
  localparam logic [2:0] CRS_THRESH_MAX = 3'h7;

  typedef enum logic [2:0] {
    CRS_ST_HOLD     = 3'b001,
    CRS_ST_DELAY    = 3'b010,
    CRS_ST_RELEASED = 3'b100
  } crs_seq_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } crs_bus_req_type;

endpackage : crs_pkg

//--- rtl/crs_sync.sv
// Two-flop synchroniser for pin inputs of the card reset block.
// Assumes inputs are asynchronous to ref_clk_i and change slowly.
`timescale 1ns/1ps
`default_nettype none

module crs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } crs_sync_state_type;

  crs_sync_state_type s_q;
  crs_sync_state_type s_d;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("crs_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second stage
  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.stable;

endmodule : crs_sync

`default_nettype wire

//--- sim/crs_card_model.sv
// Card-side model: card supply monitor and the card that sees reset.
// Assumes power_i comes from the bench on the same clock.
`timescale 1ns/1ps
`default_nettype none

module crs_card_model #(
  parameter int unsigned RAMP = 4
) (
  input  wire logic       ref_clk_i,
  input  wire logic       power_i,
  input  wire logic [1:0] deactivate_i,
  input  wire logic [1:0] card_rst_n_i,
  output logic            supply_good_o,
  output logic      [7:0] releases_o
);
  logic [3:0] ramp_q = 4'h0;
  logic [1:0] rst_q  = 2'h0;
  logic [7:0] rel_q  = 8'h00;

  // Deactivation shuts the regulator, so good drops with it
  always_ff @(posedge ref_clk_i) begin
    if (!power_i || (deactivate_i != 2'h0)) begin
      ramp_q <= 4'h0;
    end else if (ramp_q < 4'(RAMP)) begin
      ramp_q <= ramp_q + 4'h1;
    end
    rst_q <= card_rst_n_i;
    if ((card_rst_n_i & ~rst_q) != 2'h0) begin
      rel_q <= rel_q + 8'h01;
    end
  end

  assign supply_good_o = (ramp_q == 4'(RAMP));
  assign releases_o    = rel_q;
endmodule : crs_card_model

`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the card reset sequencer and supply fault block.
// Assumes the card model supplies the card supply good level.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [15:0] A_SUP = crs_pkg::CRS_ADDR_SUPPLY_CTL;
  localparam logic [15:0] A_SIG = crs_pkg::CRS_ADDR_SIGNAL_CTL;
  localparam logic [15:0] A_DLY = crs_pkg::CRS_ADDR_REL_DELAY;
  localparam logic [15:0] A_FLT = crs_pkg::CRS_ADDR_FAULT_CTL;

  logic                     ref_clk_i = 1'b0;
  logic                     nrst_i    = 1'b0;
  crs_pkg::crs_bus_req_type bus       = '0;
  logic                     tick      = 1'b0;
  logic               [1:0] sel       = 2'h0;
  logic                     below     = 1'b0;
  logic                     power     = 1'b0;
  logic               [7:0] rdata;
  logic                     good;
  logic               [1:0] rst_n;
  logic               [1:0] deact;
  logic               [2:0] thr;
  logic                     flag;
  logic               [7:0] rels;
  int                       failures  = 0;
  int                       n_checks  = 0;

  crs_card_reset #(.NUM_CARDS(2), .FACTORY_THRESHOLD(3'h2)) DUT (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
    .etu_tick_i(tick), .card_select_i(sel), .card_supply_good_i(good),
    .vdd_below_i(below), .card_rst_n_o(rst_n), .card_deactivate_o(deact),
    .supply_fault_threshold_o(thr), .supply_fault_flag_o(flag));

  crs_card_model CARD (
    .ref_clk_i(ref_clk_i), .power_i(power), .deactivate_i(deact),
    .card_rst_n_i(rst_n), .supply_good_o(good), .releases_o(rels));

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
    cyc(1);
    chk(rdata, 8'h00);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      tick <= 1'b1;
      @(posedge ref_clk_i);
      tick <= 1'b0;
      @(posedge ref_clk_i);
    end
    cyc(2);
  endtask : ticks

  task automatic stop_test;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic test_regs;
    chk({6'h0, rst_n}, 8'h00);
    chk({5'h0, thr}, 8'h02);
    rd(A_DLY, 8'h70);
    rd(A_FLT, 8'h00);
    rd(16'hFE10, 8'h00);
    wr(A_SIG, 8'hFF);
    rd(A_SIG, 8'hBF);
    wr(A_SIG, 8'h00);
    wr(A_FLT, 8'hFF);
    rd(A_FLT, 8'h67);
    wr(A_FLT, 8'h00);
    $display("test regs done");
  endtask : test_regs

  task automatic test_zero;
    int i;
    wr(A_DLY, 8'h00);
    @(posedge ref_clk_i);
    power <= 1'b1;
    // No ticks given: release may only wait for supply good
    for (i = 0; i < 20 && rst_n !== 2'b01; i++) cyc(1);
    chk({6'h0, rst_n}, 8'h01);
    if (i == 20) stop_test();
    $display("test zero delay done");
  endtask : test_zero

  task automatic test_hold;
    wr(A_DLY, 8'h03);
    // Second pass proves the counter reloads in full
    repeat (2) begin
      wr(A_SIG, 8'h80);
      cyc(2);
      chk({6'h0, rst_n}, 8'h00);
      @(posedge ref_clk_i);
      power <= 1'b0;
      cyc(6);
      @(posedge ref_clk_i);
      power <= 1'b1;
      cyc(15);
      chk({6'h0, rst_n}, 8'h00);
      wr(A_SIG, 8'h00);
      cyc(3);
      ticks(2);
      chk({6'h0, rst_n}, 8'h00);
      ticks(1);
      chk({6'h0, rst_n}, 8'h01);
    end
    $display("test hold done");
  endtask : test_hold

  task automatic test_select;
    @(posedge ref_clk_i);
    sel <= 2'h1;
    cyc(6);
    chk({6'h0, rst_n}, 8'h00);
    ticks(2);
    chk({6'h0, rst_n}, 8'h00);
    ticks(1);
    chk({6'h0, rst_n}, 8'h02);
    chk(rels, 8'h04);
    $display("test select done");
  endtask : test_select

  task automatic test_fault;
    int c;
    // Override only once power-up is over
    for (c = 0; c < 8; c++) begin
      wr(A_FLT, 8'h40 | c[7:0]);
      cyc(2);
      chk({5'h0, thr}, c[7:0]);
    end
    wr(A_FLT, 8'h05);
    cyc(2);
    chk({5'h0, thr}, 8'h02);
    @(posedge ref_clk_i);
    below <= 1'b1;
    cyc(5);
    chk({6'h0, deact}, 8'h02);
    chk({6'h0, rst_n}, 8'h00);
    chk({7'h0, flag}, 8'h01);
    rd(A_SUP, 8'h20);
    @(posedge ref_clk_i);
    below <= 1'b0;
    cyc(16);
    wr(A_SUP, 8'h20);
    rd(A_SUP, 8'h08);
    chk({7'h0, flag}, 8'h00);
    wr(A_FLT, 8'h20);
    @(posedge ref_clk_i);
    below <= 1'b1;
    cyc(6);
    chk({6'h0, deact}, 8'h00);
    chk({7'h0, flag}, 8'h00);
    rd(A_SUP, 8'h08);
    @(posedge ref_clk_i);
    below <= 1'b0;
    $display("test fault done");
  endtask : test_fault

  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    cyc(1);
    test_regs();
    test_zero();
    test_hold();
    test_select();
    test_fault();
    stop_test();
  end
endmodule : tb

`default_nettype wire
